// [fcsp_pkg.sv]
// package for the flash command/status/protection block
// assumes apb with 32-bit data, one aligned word per register
package fcsp_pkg;
    localparam logic [11:0] OFF_CONFIG  = 12'h000;
    localparam logic [11:0] OFF_PROTECT = 12'h004;
    localparam logic [11:0] OFF_STATUS  = 12'h008;
    localparam logic [11:0] OFF_COMMAND = 12'h00C;
    localparam logic [11:0] OFF_DIVIDER = 12'h010;
    localparam logic [11:0] OFF_ADDR    = 12'h014;
    localparam logic [11:0] OFF_DATA    = 12'h018;
    localparam logic [11:0] OFF_SECURE  = 12'h01C;

    localparam int BIT_KEY_WRITE_EN = 5;
    localparam int BIT_CBEF         = 7;
    localparam int BIT_CCF          = 6;
    localparam int BIT_PVIOL        = 5;
    localparam int BIT_ACCERR       = 4;
    localparam int BIT_BLANK        = 2;
    localparam int BIT_DIV_LOADED   = 7;

    localparam logic [15:0] KEY_LO = 16'hFFB0;
    localparam logic [15:0] KEY_HI = 16'hFFB7;

    localparam logic [7:0] CMD_BLANK      = 8'h05;
    localparam logic [7:0] CMD_BYTE_PROG  = 8'h20;
    localparam logic [7:0] CMD_BURST_PROG = 8'h25;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h40;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h41;

    localparam logic [7:0] ERASED_BYTE    = 8'hFF;
    localparam logic [1:0] SEC_UNSECURED  = 2'b10;
    localparam logic [1:0] SEC_RESET      = 2'b11;
    localparam logic [7:0] CONFIG_RESET   = 8'h00;
    localparam logic [7:0] DIVIDER_RESET  = 8'h00;
    localparam int         PAGE_BYTES     = 512;
    localparam int         OP_CYCLES      = 8;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_DATA, SEQ_CMD} fcsp_seq_t;
    typedef enum logic [1:0] {EXE_IDLE, EXE_RUN, EXE_BLANK} fcsp_exe_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic [7:0]  code;
    } fcsp_cmd_t;
endpackage

// [fcsp_cmd_buf.sv]
// one-entry command holding register with registered read-out
// assumes writer checks full before loading
`timescale 1ns/100ps
`default_nettype none
module fcsp_cmd_buf (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               load,
    input  wire fcsp_pkg::fcsp_cmd_t wdata,
    input  wire logic               take,
    output var  logic               full,
    output var  fcsp_pkg::fcsp_cmd_t rdata
);
    logic                full_next;
    fcsp_pkg::fcsp_cmd_t rdata_next;

    always_comb begin
        full_next  = full;
        rdata_next = rdata;
        if (take) begin
            full_next = 1'b0;
        end
        if (load) begin
            full_next  = 1'b1;
            rdata_next = wdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            full  <= 1'b0;
            rdata <= '0;
        end else begin
            full  <= full_next;
            rdata <= rdata_next;
        end
    end
endmodule // fcsp_cmd_buf
`default_nettype wire

// [fcsp_top.sv]
// flash command, status and protection control face on apb
// assumes the array interface answers a one-cycle op pulse with array_done,
// and nv_protection is stable at the first pclk edge after presetn is released
//
// Implementation choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Operation
// - key enable 0: key region write starts a command
// - key enable 1: key region writes feed key compare
// - protection loads from copy on first edge after reset; always readable
// - enabled protection: only lower protect-select taken
// - disabled protection: protection writes ignored
// - protect-select ends unprotected area; above rejects
// - disable bit one: nothing protected
// - debug may overwrite protection
// - write one to buffer-empty launches
// - only burst program buffered
// - complete when idle and empty; read-only
// - protected target: violation, command dropped
// - bad order, no divider, stop: access error
// - blank set by erased blank check
// - codes 05 blank, 20 byte, 25 burst
// - 40 page erase, 41 mass erase
// - other codes: access error
// - program, erase off until divider written
// - erased blank check unsecures
module fcsp_top #(
    parameter int AW = 16
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    output var  logic [31:0]   prdata,
    output var  logic          pready,
    output var  logic          pslverr,
    input  wire logic [7:0]    nv_protection,
    input  wire logic          dbg_prot_we,
    input  wire logic [7:0]    dbg_prot_data,
    input  wire logic          stop_req,
    input  wire logic          array_done,
    input  wire logic          array_erased,
    output var  logic          array_op,
    output var  logic [7:0]    array_code,
    output var  logic [15:0]   array_addr,
    output var  logic [7:0]    array_data,
    output var  logic          key_wr,
    output var  logic [2:0]    key_idx,
    output var  logic [7:0]    key_data,
    output var  logic [1:0]    security_state_code
);
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic is_legal(input logic [7:0] c);
        is_legal = (c == fcsp_pkg::CMD_BLANK) || (c == fcsp_pkg::CMD_BYTE_PROG) ||
                   (c == fcsp_pkg::CMD_BURST_PROG) || (c == fcsp_pkg::CMD_PAGE_ERASE) ||
                   (c == fcsp_pkg::CMD_MASS_ERASE);
    endfunction

    // protected unless disabled: above the unprotected end; mass erase always, blank check never
    function automatic logic is_protected(input logic [7:0] prot, input logic [15:0] a,
                                          input logic [7:0] c);
        logic [15:0] lim;
        lim = {prot[7:1], 9'h1FF};
        if (prot[0]) begin
            is_protected = 1'b0;
        end else if (c == fcsp_pkg::CMD_MASS_ERASE) begin
            is_protected = 1'b1;
        end else if (c == fcsp_pkg::CMD_BLANK) begin
            is_protected = 1'b0;
        end else begin
            is_protected = a > lim;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    wire logic wr_en = psel && penable && pwrite;
    wire logic rd_en = psel && !penable && !pwrite;

    logic [7:0]  config_reg, config_next;
    logic [7:0]  protect_reg, protect_next;
    logic [7:0]  divider_reg, divider_next;
    logic        div_loaded_reg, div_loaded_next;
    logic [7:0]  command_reg, command_next;
    logic [15:0] addr_reg, addr_next;
    logic [7:0]  data_reg, data_next;
    logic        cbef_reg, cbef_next;
    logic        ccf_reg, ccf_next;
    logic        pviol_reg, pviol_next;
    logic        accerr_reg, accerr_next;
    logic        blank_reg, blank_next;
    logic [1:0]  sec_reg, sec_next;
    logic        prot_loaded_reg, prot_loaded_next;
    fcsp_pkg::fcsp_seq_t seq_reg, seq_next;
    fcsp_pkg::fcsp_exe_t exe_reg, exe_next;
    logic        op_reg, op_next;
    logic [7:0]  op_code_reg, op_code_next;
    logic [15:0] op_addr_reg, op_addr_next;
    logic [7:0]  op_data_reg, op_data_next;
    logic        key_wr_reg, key_wr_next;
    logic [2:0]  key_idx_reg, key_idx_next;
    logic [7:0]  key_data_reg, key_data_next;
    logic [31:0] prdata_reg, prdata_next;
    logic        pready_reg, pready_next;
    logic        pslverr_reg, pslverr_next;

    logic                buf_load, buf_take, buf_full;
    fcsp_pkg::fcsp_cmd_t buf_wdata, buf_rdata;

    fcsp_cmd_buf u_buf (
        .pclk    (pclk),
        .presetn (presetn),
        .load    (buf_load),
        .wdata   (buf_wdata),
        .take    (buf_take),
        .full    (buf_full),
        .rdata   (buf_rdata)
    );

    logic [7:0] status_view;
    assign status_view = {cbef_reg, ccf_reg, pviol_reg, accerr_reg, 1'b0, blank_reg, 2'b00};

    wire logic mapped = (paddr <= fcsp_pkg::OFF_SECURE) && (paddr[1:0] == 2'b00);

    ////////////////////////////////////////////////////////////////////////////
    // bus and register side
    always_comb begin
        config_next      = config_reg;
        protect_next     = protect_reg;
        divider_next     = divider_reg;
        div_loaded_next  = div_loaded_reg;
        command_next     = command_reg;
        addr_next        = addr_reg;
        data_next        = data_reg;
        cbef_next        = cbef_reg;
        ccf_next         = ccf_reg;
        pviol_next       = pviol_reg;
        accerr_next      = accerr_reg;
        blank_next       = blank_reg;
        sec_next         = sec_reg;
        prot_loaded_next = 1'b1;
        seq_next         = seq_reg;
        exe_next         = exe_reg;
        op_next          = 1'b0;
        op_code_next     = op_code_reg;
        op_addr_next     = op_addr_reg;
        op_data_next     = op_data_reg;
        key_wr_next      = 1'b0;
        key_idx_next     = key_idx_reg;
        key_data_next    = key_data_reg;
        prdata_next      = prdata_reg;
        pready_next      = rd_en || (psel && !penable && pwrite);
        pslverr_next     = psel && !penable && !mapped;
        buf_load         = 1'b0;
        buf_take         = 1'b0;
        buf_wdata        = '{addr: addr_reg, data: data_reg, code: command_reg};

        // catch the nonvolatile copy on the first edge after release
        if (!prot_loaded_reg) begin
            protect_next = nv_protection;
        end

        if (rd_en) begin
            unique case (paddr)
                fcsp_pkg::OFF_CONFIG:  prdata_next = {24'h0000_00, config_reg};
                fcsp_pkg::OFF_PROTECT: prdata_next = {24'h0000_00, protect_reg};
                fcsp_pkg::OFF_STATUS:  prdata_next = {24'h0000_00, status_view};
                fcsp_pkg::OFF_COMMAND: prdata_next = {24'h0000_00, command_reg};
                fcsp_pkg::OFF_DIVIDER: prdata_next = {24'h0000_00, div_loaded_reg,
                                                      divider_reg[6:0]};
                fcsp_pkg::OFF_ADDR:    prdata_next = {16'h0000, addr_reg};
                fcsp_pkg::OFF_DATA:    prdata_next = {24'h0000_00, data_reg};
                fcsp_pkg::OFF_SECURE:  prdata_next = {30'h0000_0000, sec_reg};
                default:               prdata_next = 32'h0000_0000;
            endcase
        end

        // array completion and blank result
        if (exe_reg != fcsp_pkg::EXE_IDLE && array_done) begin
            if (exe_reg == fcsp_pkg::EXE_BLANK && array_erased) begin
                blank_next = 1'b1;
                sec_next   = fcsp_pkg::SEC_UNSECURED;
            end
            exe_next = fcsp_pkg::EXE_IDLE;
        end
        if (exe_reg != fcsp_pkg::EXE_IDLE && stop_req) begin
            exe_next    = fcsp_pkg::EXE_IDLE;
        end

        // move a buffered burst program onto the array when it goes idle
        if (buf_full && exe_next == fcsp_pkg::EXE_IDLE && !op_reg) begin
            buf_take     = 1'b1;
            op_next      = 1'b1;
            op_code_next = buf_rdata.code;
            op_addr_next = buf_rdata.addr;
            op_data_next = buf_rdata.data;
            exe_next     = fcsp_pkg::EXE_RUN;
            cbef_next    = 1'b1;
        end

        if (wr_en) begin
            unique case (paddr)
                fcsp_pkg::OFF_CONFIG: config_next = pwdata[7:0];
                fcsp_pkg::OFF_PROTECT: begin
                    if (!protect_reg[0] && pwdata[7:1] < protect_reg[7:1]) begin
                        protect_next = {pwdata[7:1], 1'b0};
                    end
                    // disabled protection keeps its setting untouched
                end
                fcsp_pkg::OFF_DIVIDER: begin
                    divider_next    = pwdata[7:0];
                    div_loaded_next = 1'b1;
                end
                fcsp_pkg::OFF_ADDR: begin
                    addr_next = pwdata[15:0];
                    if (config_reg[fcsp_pkg::BIT_KEY_WRITE_EN] &&
                        pwdata[15:0] >= fcsp_pkg::KEY_LO && pwdata[15:0] <= fcsp_pkg::KEY_HI) begin
                        key_idx_next = pwdata[2:0];
                    end
                end
                fcsp_pkg::OFF_DATA: begin
                    if (config_reg[fcsp_pkg::BIT_KEY_WRITE_EN] &&
                        addr_reg >= fcsp_pkg::KEY_LO && addr_reg <= fcsp_pkg::KEY_HI) begin
                        key_wr_next   = 1'b1;
                        key_data_next = pwdata[7:0];
                    end else if (seq_reg == fcsp_pkg::SEQ_IDLE && cbef_reg) begin
                        data_next = pwdata[7:0];
                        seq_next  = fcsp_pkg::SEQ_DATA;
                    end else begin
                        accerr_next = 1'b1;
                        seq_next    = fcsp_pkg::SEQ_IDLE;
                    end
                end
                fcsp_pkg::OFF_COMMAND: begin
                    command_next = pwdata[7:0];
                    if (seq_reg == fcsp_pkg::SEQ_DATA && is_legal(pwdata[7:0])) begin
                        seq_next = fcsp_pkg::SEQ_CMD;
                    end else begin
                        accerr_next = 1'b1;
                        seq_next    = fcsp_pkg::SEQ_IDLE;
                    end
                end
                fcsp_pkg::OFF_STATUS: begin
                    if (pwdata[fcsp_pkg::BIT_PVIOL]) begin
                        pviol_next = 1'b0;
                    end
                    if (pwdata[fcsp_pkg::BIT_ACCERR]) begin
                        accerr_next = 1'b0;
                    end
                    if (pwdata[fcsp_pkg::BIT_CBEF] && cbef_reg) begin
                        if (seq_reg != fcsp_pkg::SEQ_CMD || pviol_reg || accerr_reg) begin
                            accerr_next = 1'b1;
                        end else if (command_reg != fcsp_pkg::CMD_BLANK && !div_loaded_reg) begin
                            accerr_next = 1'b1;
                        end else if (command_reg != fcsp_pkg::CMD_BLANK &&
                                     is_protected(protect_reg, addr_reg, command_reg)) begin
                            pviol_next = 1'b1;
                        end else begin
                            cbef_next  = 1'b0;
                            blank_next = 1'b0;
                            if (exe_next == fcsp_pkg::EXE_IDLE && !buf_take) begin
                                op_next      = 1'b1;
                                op_code_next = command_reg;
                                op_addr_next = addr_reg;
                                op_data_next = data_reg;
                                exe_next     = (command_reg == fcsp_pkg::CMD_BLANK) ?
                                               fcsp_pkg::EXE_BLANK : fcsp_pkg::EXE_RUN;
                                cbef_next    = 1'b1;
                            end else begin
                                // busy: only burst programs may wait
                                buf_load = (command_reg == fcsp_pkg::CMD_BURST_PROG);
                                if (command_reg != fcsp_pkg::CMD_BURST_PROG) begin
                                    accerr_next = 1'b1;
                                    cbef_next   = 1'b1;
                                end
                            end
                        end
                        seq_next = fcsp_pkg::SEQ_IDLE;
                    end
                end
                default: ;
            endcase
        end

        // an in-flight error keeps its flag even against a same-cycle clear
        if (exe_reg != fcsp_pkg::EXE_IDLE && stop_req) begin
            accerr_next = 1'b1;
        end
        if (dbg_prot_we) begin
            protect_next = dbg_prot_data;
        end
        ccf_next = (exe_next == fcsp_pkg::EXE_IDLE) && !op_next &&
                   !buf_full && !buf_load;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_reg      <= fcsp_pkg::CONFIG_RESET;
            protect_reg     <= 8'h01;
            divider_reg     <= fcsp_pkg::DIVIDER_RESET;
            div_loaded_reg  <= 1'b0;
            command_reg     <= 8'h00;
            addr_reg        <= 16'h0000;
            data_reg        <= 8'h00;
            cbef_reg        <= 1'b1;
            ccf_reg         <= 1'b1;
            pviol_reg       <= 1'b0;
            accerr_reg      <= 1'b0;
            blank_reg       <= 1'b0;
            sec_reg         <= fcsp_pkg::SEC_RESET;
            prot_loaded_reg <= 1'b0;
            seq_reg         <= fcsp_pkg::SEQ_IDLE;
            exe_reg         <= fcsp_pkg::EXE_IDLE;
            op_reg          <= 1'b0;
            op_code_reg     <= 8'h00;
            op_addr_reg     <= 16'h0000;
            op_data_reg     <= 8'h00;
            key_wr_reg      <= 1'b0;
            key_idx_reg     <= 3'b000;
            key_data_reg    <= 8'h00;
            prdata_reg      <= 32'h0000_0000;
            pready_reg      <= 1'b0;
            pslverr_reg     <= 1'b0;
        end else begin
            config_reg      <= config_next;
            protect_reg     <= protect_next;
            divider_reg     <= divider_next;
            div_loaded_reg  <= div_loaded_next;
            command_reg     <= command_next;
            addr_reg        <= addr_next;
            data_reg        <= data_next;
            cbef_reg        <= cbef_next;
            ccf_reg         <= ccf_next;
            pviol_reg       <= pviol_next;
            accerr_reg      <= accerr_next;
            blank_reg       <= blank_next;
            sec_reg         <= sec_next;
            prot_loaded_reg <= prot_loaded_next;
            seq_reg         <= seq_next;
            exe_reg         <= exe_next;
            op_reg          <= op_next;
            op_code_reg     <= op_code_next;
            op_addr_reg     <= op_addr_next;
            op_data_reg     <= op_data_next;
            key_wr_reg      <= key_wr_next;
            key_idx_reg     <= key_idx_next;
            key_data_reg    <= key_data_next;
            prdata_reg      <= prdata_next;
            pready_reg      <= pready_next;
            pslverr_reg     <= pslverr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign array_op            = op_reg;
    assign array_code          = op_code_reg;
    assign array_addr          = op_addr_reg;
    assign array_data          = op_data_reg;
    assign key_wr              = key_wr_reg;
    assign key_idx             = key_idx_reg;
    assign key_data            = key_data_reg;
    assign security_state_code = sec_reg;
endmodule // fcsp_top
`default_nettype wire

// [fcsp_array_model.sv]
// stand-in for the flash array: answers each op pulse with one done pulse
// assumes one op at a time; slow stretches the answer so ops overlap bus traffic
`timescale 1ns/100ps
`default_nettype none
module fcsp_array_model (
    input  wire logic       pclk,
    input  wire logic       array_op,
    input  wire logic [7:0] array_code,
    input  wire logic       slow,
    output var  logic       array_done,
    output var  logic       array_erased
);
    logic erased_reg = 1'b0;
    logic done_reg   = 1'b0;
    int   wait_reg   = 0;
    always @(posedge pclk) begin
        done_reg <= 1'b0;
        if (array_op)
            wait_reg <= slow ? 30 : 3;
        else if (wait_reg > 0)
            wait_reg <= wait_reg - 1;
        if (wait_reg == 1) begin
            done_reg <= 1'b1;
            // no blank check is needed to make the array erased
            if (array_code == fcsp_pkg::CMD_MASS_ERASE)
                erased_reg <= 1'b1;
            else if (array_code != fcsp_pkg::CMD_BLANK)
                erased_reg <= 1'b0;
        end
    end
    assign array_done = done_reg;
    // only valid beside done; elsewhere the line shows the inverse
    assign array_erased = done_reg ? erased_reg : ~erased_reg;
endmodule // fcsp_array_model
`default_nettype wire

// [fcsp_checker.sv]
// assertion checker for the flash control face, bound to fcsp_top
// assumes zero-wait apb answers and registered one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
module fcsp_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        array_op,
    input wire logic        array_done,
    input wire logic        key_wr,
    input wire logic [1:0]  security_state_code
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic wr_acc;
    logic launch_wr;
    assign wr_acc = psel && penable && pwrite && pready;
    assign launch_wr = wr_acc && paddr == fcsp_pkg::OFF_STATUS && pwdata[7];
    answer_in_access_a: assert property (psel && !penable |=> pready && penable)
        else $error("missing answer");
    answer_one_cycle_a: assert property (pready |=> !pready)
        else $error("answer too long");
    error_with_ready_a: assert property (pslverr |-> pready)
        else $error("stray slave error");
    unmapped_error_a: assert property (psel && !penable && paddr > 12'h01C |=> pslverr)
        else $error("unmapped not refused");
    op_one_pulse_a: assert property (array_op |=> !array_op)
        else $error("op pulse too long");
    op_has_cause_a: assert property ($rose(array_op) |->
        $past(launch_wr) || $past(array_done) || $past(array_done, 2))
        else $error("op without launch");
    key_from_data_a: assert property (key_wr |-> $past(wr_acc && paddr == fcsp_pkg::OFF_DATA))
        else $error("stray key write");
    unlock_after_done_a: assert property ($changed(security_state_code) |->
        security_state_code == fcsp_pkg::SEC_UNSECURED && $past(array_done))
        else $error("bad security change");
    read_upper_zero_a: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read bits set");
endmodule // fcsp_checker
bind fcsp_top fcsp_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .array_op, .array_done, .key_wr, .security_state_code);
`default_nettype wire

// [fcsp_bench.sv]
// self-checking bench for fcsp_top with the flash array stand-in
// assumes zero-wait apb and a one-entry burst buffer
`timescale 1ns/100ps
`default_nettype none
module fcsp_bench;
    localparam logic [11:0] ST = fcsp_pkg::OFF_STATUS, PR = fcsp_pkg::OFF_PROTECT;
    localparam logic [7:0]  BP = fcsp_pkg::CMD_BYTE_PROG;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic dbg_prot_we = 0, stop_req = 0, slow = 0, pready, pslverr;
    logic array_op, array_done, array_erased, key_wr;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, last, lfsr = 32'hdfd4_78b6, oq[$];
    logic [7:0]  dbg_prot_data = 0, array_code, array_data, key_data;
    logic [15:0] array_addr;
    logic [2:0]  key_idx;
    logic [1:0]  security_state_code;
    logic [63:0] note, rq[$];
    logic [7:0]  codes[5] = '{8'h41, 8'h05, 8'h40, 8'h25, 8'h20};
    int n_fail = 0, compares = 0;
    fcsp_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .nv_protection(8'h80), .dbg_prot_we, .dbg_prot_data, .stop_req,
        .array_done, .array_erased, .array_op, .array_code, .array_addr, .array_data,
        .key_wr, .key_idx, .key_data, .security_state_code);
    fcsp_array_model flash (.pclk, .array_op, .array_code, .slow, .array_done, .array_erased);
    initial forever #50 pclk = ~pclk;
    function automatic logic [31:0] lfsr_step(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        last = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
        rq.push_back({m, e});
        apb(0, a, 0);
    endtask
    task automatic cmd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c, input bit ok);
        if (ok)
            oq.push_back({c, a, d});
        apb(1, fcsp_pkg::OFF_ADDR, {16'h0, a});
        apb(1, fcsp_pkg::OFF_DATA, {24'h0, d});
        apb(1, fcsp_pkg::OFF_COMMAND, {24'h0, c});
        apb(1, ST, 32'h80);
    endtask
    // flag reads set, writing one clears it
    task automatic err(input logic [7:0] f);
        rd(ST, {24'h0, f}, {24'h0, f});
        apb(1, ST, {24'h0, f});
        rd(ST, 0, {24'h0, f});
    endtask
    task automatic wait_idle();
        repeat (100) begin
            rd(ST, 0, 0);
            if (last[6]) break;
        end
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge pclk) begin
        if (pready === 1'b1 && !pwrite && rq.size() > 0) begin
            note = rq.pop_front();
            if (note[63:32] != 0) check(prdata & note[63:32], note[31:0]);
        end
        if (array_op === 1'b1)
            check({array_code, array_addr, array_data}, oq.size() ? oq.pop_front() : 'x);
        if (key_wr === 1'b1)
            check({21'h0, key_idx, key_data}, oq.size() ? oq.pop_front() : 'x);
    end
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        final_report();
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(PR, 32'h80, '1);
        rd(ST, 32'hC0, '1);
        rd(fcsp_pkg::OFF_SECURE, 32'h3, '1);
        apb(0, 12'h020, 0);
        cmd(16'h1000, 8'h5A, BP, 0);
        apb(1, ST, 0);
        err(8'h10);
        apb(1, fcsp_pkg::OFF_DIVIDER, 32'h31);
        rd(fcsp_pkg::OFF_DIVIDER, 32'h80, 32'h80);
        cmd(16'h1000, 8'h11, 8'h33, 0);
        err(8'h10);
        $display("test start done");
        apb(1, PR, 32'h90);
        rd(PR, 32'h80, '1);
        apb(1, PR, 32'h60);
        rd(PR, 32'h60, '1);
        cmd(16'h6200, 8'hA5, BP, 0);
        err(8'h20);
        cmd(16'h61FF, 8'hA5, BP, 1);
        wait_idle();
        cmd(16'h0000, 8'hFF, fcsp_pkg::CMD_MASS_ERASE, 0);
        err(8'h20);
        dbg_prot_we <= 1;
        dbg_prot_data <= 8'h01;
        @(posedge pclk);
        dbg_prot_we <= 0;
        rd(PR, 32'h1, '1);
        apb(1, PR, 0);
        rd(PR, 32'h1, '1);
        $display("test protection done");
        for (int i = 0; i < 5; i++) begin
            lfsr = lfsr_step(lfsr);
            cmd(lfsr[15:0], lfsr[23:16], codes[i], 1);
            wait_idle();
            rd(ST, (i == 1) ? 32'hC4 : 32'hC0, 32'hF4);
        end
        rd(fcsp_pkg::OFF_SECURE, 32'h2, '1);
        cmd(16'hFFB4, 8'h3C, BP, 1);
        wait_idle();
        apb(1, fcsp_pkg::OFF_CONFIG, 32'h20);
        apb(1, fcsp_pkg::OFF_ADDR, 32'hFFB3);
        oq.push_back({21'h0, 3'd3, 8'h5A});
        apb(1, fcsp_pkg::OFF_DATA, 32'h5A);
        apb(1, fcsp_pkg::OFF_CONFIG, 0);
        $display("test codes done");
        slow <= 1;
        cmd(16'h2000, 8'h01, fcsp_pkg::CMD_BURST_PROG, 1);
        cmd(16'h2001, 8'h02, fcsp_pkg::CMD_BURST_PROG, 1);
        rd(ST, 0, 32'h80);
        wait_idle();
        rd(ST, 32'hC0, 32'hF0);
        cmd(16'h3000, 8'h03, BP, 1);
        stop_req <= 1;
        repeat (2) @(posedge pclk);
        stop_req <= 0;
        wait_idle();
        err(8'h10);
        repeat (40) @(posedge pclk);
        check(32'(oq.size() + rq.size()), 0);
        $display("test burst and stop done");
        final_report();
    end
endmodule // fcsp_bench
`default_nettype wire
